// file: design/lpt_engine.sv
// Purpose: Raster timing engine and display-bus transfer engine sharing one pin set
// Assumes: pix_clk_ref_i is asynchronous and much slower than mclk_i
// Notes: All pin outputs are registered; read data passes a two-flop synchroniser
// ==========================================================
// What this block does
// R1: Enable-strobe flavour is asynchronous, no free clock
// R2: Enable-strobe flavour pulses memory clock pin
// R3: Other flavours select asynchronous or synchronous transfers
// R4: Asynchronous mode drives memory clock as chip select
// R5: Synchronous mode drives memory clock as running clock
// R6: Frame timing from porches, sync width, lines
// R7: Line timing from porches, sync width, pixels
// R8: AC-bias output timed by programmed frequency
// R9: Frame delivered line by line, left to right
// R10: Frame sync marks each new frame
// R11: Line sync marks each new line
// R12: Only one engine active at a time
// R13: Counters cover 2048 pixels and 2048 lines
// R14: Bus control and data timing programmable
// R15: Order sync, back porch, active, front porch
// R16: Raster pins repurposed as bus control pins
module lpt_engine
  import lpt_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic display_bus_mode_i,
  input wire logic [1:0] bus_flavour_i,
  input wire logic bus_sync_i,
  input wire logic [7:0] vertical_front_porch_i,
  input wire logic [5:0] vertical_sync_width_i,
  input wire logic [7:0] vertical_back_porch_i,
  input wire logic [9:0] line_count_low_i,
  input wire logic line_count_ext_bit_i,
  input wire logic [7:0] horizontal_front_porch_i,
  input wire logic [5:0] horizontal_sync_width_i,
  input wire logic [7:0] horizontal_back_porch_i,
  input wire logic pixels_per_line_high_i,
  input wire logic [5:0] pixels_per_line_low_i,
  input wire logic [7:0] ac_bias_frequency_i,
  input wire logic [4:0] setup_cycles_i,
  input wire logic [5:0] strobe_cycles_i,
  input wire logic [3:0] hold_cycles_i,
  input wire logic [1:0] cs_delay_i,
  input wire logic pix_clk_ref_i,
  input wire logic pix_valid_i,
  input wire logic [PIX_W-1:0] pix_data_i,
  output logic pix_ready_o,
  input wire logic cmd_valid_i,
  input wire logic cmd_write_i,
  input wire logic cmd_reg_sel_i,
  input wire logic [PIX_W-1:0] cmd_data_i,
  output logic cmd_ready_o,
  output logic rd_valid_o,
  output logic [PIX_W-1:0] rd_data_o,
  output logic memory_clock_pin_o,
  output logic frame_sync_out_o,
  output logic line_sync_out_o,
  output logic pixel_clock_out_o,
  output logic ac_bias_out_o,
  output logic read_strobe_n_o,
  output logic [PIX_W-1:0] pixel_data_bus_o,
  input wire logic [PIX_W-1:0] pixel_data_bus_i,
  output logic pixel_data_bus_oe_n_o
);
  // ==========================================================
  // Helpers
  function automatic lpt_phase_e next_ph(input lpt_phase_e ph);
    case (ph)
      PH_SYNC: next_ph = PH_BACK;
      PH_BACK: next_ph = PH_ACT;
      PH_ACT: next_ph = PH_FRONT;
      default: next_ph = PH_SYNC;
    endcase
  endfunction

  function automatic logic [CNT_W-1:0] ph_len(input lpt_phase_e ph, input logic [CNT_W-1:0] s,
                                             input logic [CNT_W-1:0] b, input logic [CNT_W-1:0] a,
                                             input logic [CNT_W-1:0] f);
    case (ph)
      PH_SYNC: ph_len = s;
      PH_BACK: ph_len = b;
      PH_ACT: ph_len = a;
      default: ph_len = f;
    endcase
  endfunction

  // ==========================================================
  // Interval lengths
  logic [CNT_W-1:0] h_s, h_b, h_a, h_f, v_s, v_b, v_a, v_f;
  assign h_s = CNT_W'(horizontal_sync_width_i) + 12'h001; // R7
  assign h_b = CNT_W'(horizontal_back_porch_i) + 12'h001; // R7
  // Widen before the add so the largest code still gives 2048 pixels
  assign h_a = (CNT_W'({pixels_per_line_high_i, pixels_per_line_low_i}) + 12'h001) << PPL_SHIFT; // R7 R13
  assign h_f = CNT_W'(horizontal_front_porch_i) + 12'h001; // R7
  assign v_s = CNT_W'(vertical_sync_width_i) + 12'h001; // R6
  assign v_b = CNT_W'(vertical_back_porch_i); // R6
  assign v_a = CNT_W'({line_count_ext_bit_i, line_count_low_i}) + 12'h001; // R6 R13
  assign v_f = CNT_W'(vertical_front_porch_i); // R6

  // ==========================================================
  // Pixel clock reference synchroniser and edge finder
  logic pck_s1_r, pck_s2_r, pck_s3_r, pck_rise;
  logic [PIX_W-1:0] din_s1_r, din_s2_r;
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      pck_s1_r <= 1'b0;
      pck_s2_r <= 1'b0;
      pck_s3_r <= 1'b0;
      din_s1_r <= PIX_RESET;
      din_s2_r <= PIX_RESET;
    end else begin
      pck_s1_r <= pix_clk_ref_i;
      pck_s2_r <= pck_s1_r;
      pck_s3_r <= pck_s2_r;
      din_s1_r <= pixel_data_bus_i;
      din_s2_r <= din_s1_r;
    end
  end
  assign pck_rise = pck_s2_r & ~pck_s3_r;

  // ==========================================================
  // Two-entry pixel buffer
  logic [PIX_W-1:0] fifo_mem_r [FIFO_DEPTH];
  logic wr_ptr_r, rd_ptr_r, wr_ptr_nxt, rd_ptr_nxt;
  logic [1:0] fcnt_r, fcnt_nxt;
  logic push, pop, pix_take;
  lpt_phase_e h_st_r, h_st_nxt, v_st_r, v_st_nxt;
  assign pix_ready_o = (fcnt_r != 2'h2);
  assign push = pix_valid_i & pix_ready_o;
  // Blank lines consume no pixels, so the frame holds exactly the active lines
  assign pix_take = pck_rise & ~display_bus_mode_i & (h_st_r == PH_ACT) & (v_st_r == PH_ACT); // R9
  assign pop = pix_take & (fcnt_r != 2'h0);
  always_comb begin
    wr_ptr_nxt = push ? ~wr_ptr_r : wr_ptr_r;
    rd_ptr_nxt = pop ? ~rd_ptr_r : rd_ptr_r;
    fcnt_nxt = fcnt_r + {1'b0, push} - {1'b0, pop};
  end
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      fcnt_r <= 2'h0;
    end else begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      fcnt_r <= fcnt_nxt;
    end
    if (push) begin
      fifo_mem_r[wr_ptr_r] <= pix_data_i;
    end
  end

  // ==========================================================
  // Raster counters; held parked while the bus engine owns the pins
  logic [CNT_W-1:0] hcnt_r, hcnt_nxt, vcnt_r, vcnt_nxt;
  logic [7:0] acnt_r, acnt_nxt;
  logic ac_r, ac_nxt;
  logic [PIX_W-1:0] pix_r, pix_nxt;
  always_comb begin
    h_st_nxt = h_st_r;
    v_st_nxt = v_st_r;
    hcnt_nxt = hcnt_r;
    vcnt_nxt = vcnt_r;
    acnt_nxt = acnt_r;
    ac_nxt = ac_r;
    pix_nxt = pix_r;
    if (display_bus_mode_i) begin
      h_st_nxt = PH_SYNC; // R12
      v_st_nxt = PH_SYNC; // R12
      hcnt_nxt = CNT_ZERO;
      vcnt_nxt = CNT_ZERO;
    end else if (pck_rise) begin
      if (pix_take) begin
        pix_nxt = (fcnt_r != 2'h0) ? fifo_mem_r[rd_ptr_r] : PIX_RESET; // R9
      end
      if (hcnt_r + 12'h001 >= ph_len(h_st_r, h_s, h_b, h_a, h_f)) begin
        hcnt_nxt = CNT_ZERO;
        h_st_nxt = next_ph(h_st_r); // R15
        if (h_st_r == PH_FRONT) begin
          if (acnt_r == ac_bias_frequency_i) begin
            acnt_nxt = 8'h00;
            ac_nxt = ~ac_r; // R8
          end else begin
            acnt_nxt = acnt_r + 8'h01;
          end
          if (vcnt_r + 12'h001 >= ph_len(v_st_r, v_s, v_b, v_a, v_f)) begin
            vcnt_nxt = CNT_ZERO;
            v_st_nxt = next_ph(v_st_r); // R15
            // Zero-length porches are skipped so no empty phase lingers a line
            if (ph_len(v_st_nxt, v_s, v_b, v_a, v_f) == CNT_ZERO) begin
              v_st_nxt = next_ph(v_st_nxt);
            end
          end else begin
            vcnt_nxt = vcnt_r + 12'h001; // R9
          end
        end
      end else begin
        hcnt_nxt = hcnt_r + 12'h001; // R9
      end
    end
  end
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      h_st_r <= PH_SYNC;
      v_st_r <= PH_SYNC;
      hcnt_r <= CNT_ZERO;
      vcnt_r <= CNT_ZERO;
      acnt_r <= 8'h00;
      ac_r <= 1'b0;
      pix_r <= PIX_RESET;
    end else begin
      h_st_r <= h_st_nxt;
      v_st_r <= v_st_nxt;
      hcnt_r <= hcnt_nxt;
      vcnt_r <= vcnt_nxt;
      acnt_r <= acnt_nxt;
      ac_r <= ac_nxt;
      pix_r <= pix_nxt;
    end
  end

  // ==========================================================
  // Display-bus transfer sequencer
  lpt_bus_e bs_r, bs_nxt;
  logic [BCNT_W-1:0] bcnt_r, bcnt_nxt, bcnt_inc;
  logic wr_r, wr_nxt, rs_r, rs_nxt, rdv_r, rdv_nxt, div_r;
  logic [PIX_W-1:0] cdat_r, cdat_nxt, rdat_r, rdat_nxt;
  assign cmd_ready_o = display_bus_mode_i & (bs_r == BS_IDLE); // R12
  assign bcnt_inc = bcnt_r + 6'h01;
  always_comb begin
    bs_nxt = bs_r;
    bcnt_nxt = bcnt_r;
    wr_nxt = wr_r;
    rs_nxt = rs_r;
    cdat_nxt = cdat_r;
    rdat_nxt = rdat_r;
    rdv_nxt = 1'b0;
    case (bs_r)
      BS_IDLE: begin
        if (cmd_valid_i & cmd_ready_o) begin
          wr_nxt = cmd_write_i;
          rs_nxt = cmd_reg_sel_i;
          cdat_nxt = cmd_data_i;
          bcnt_nxt = BCNT_ZERO;
          bs_nxt = (setup_cycles_i != 5'h00) ? BS_SETUP : BS_STROBE; // R14
        end
      end
      BS_SETUP: begin
        bcnt_nxt = bcnt_inc;
        if (bcnt_inc >= BCNT_W'(setup_cycles_i)) begin
          bcnt_nxt = BCNT_ZERO;
          bs_nxt = BS_STROBE; // R14
        end
      end
      BS_STROBE: begin
        bcnt_nxt = bcnt_inc;
        if (bcnt_inc >= strobe_cycles_i) begin
          bcnt_nxt = BCNT_ZERO;
          bs_nxt = BS_HOLD; // R14
          if (!wr_r) begin
            rdat_nxt = din_s2_r;
            rdv_nxt = 1'b1;
          end
        end
      end
      BS_HOLD: begin
        bcnt_nxt = bcnt_inc;
        if (bcnt_inc >= BCNT_W'(hold_cycles_i)) begin
          bcnt_nxt = BCNT_ZERO;
          bs_nxt = (cs_delay_i != 2'h0) ? BS_GAP : BS_IDLE; // R14
        end
      end
      default: begin
        bcnt_nxt = bcnt_inc;
        if (bcnt_inc >= BCNT_W'(cs_delay_i)) begin
          bcnt_nxt = BCNT_ZERO;
          bs_nxt = BS_IDLE;
        end
      end
    endcase
  end
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      bs_r <= BS_IDLE;
      bcnt_r <= BCNT_ZERO;
      wr_r <= 1'b0;
      rs_r <= 1'b0;
      cdat_r <= PIX_RESET;
      rdat_r <= PIX_RESET;
      rdv_r <= 1'b0;
      div_r <= 1'b0;
    end else begin
      bs_r <= bs_nxt;
      bcnt_r <= bcnt_nxt;
      wr_r <= wr_nxt;
      rs_r <= rs_nxt;
      cdat_r <= cdat_nxt;
      rdat_r <= rdat_nxt;
      rdv_r <= rdv_nxt;
      div_r <= ~div_r;
    end
  end
  assign rd_valid_o = rdv_r;
  assign rd_data_o = rdat_r;

  // ==========================================================
  // Pin multiplexing, registered so every pin leaves a flip-flop
  logic xfer, strb;
  logic mck_nxt, fs_nxt, ls_nxt, pc_nxt, acp_nxt, rsn_nxt, oen_nxt;
  logic [PIX_W-1:0] dat_nxt;
  assign xfer = (bs_r == BS_SETUP) | (bs_r == BS_STROBE) | (bs_r == BS_HOLD);
  assign strb = (bs_r == BS_STROBE);
  always_comb begin
    if (display_bus_mode_i) begin
      fs_nxt = (bs_r == BS_SETUP); // R16
      ls_nxt = (bus_flavour_i == FLAV_RWSTROBE) ? ~(strb & wr_r) : ~(xfer & wr_r); // R16
      pc_nxt = rs_r; // R16
      acp_nxt = ~xfer; // R16
      rsn_nxt = (bus_flavour_i == FLAV_ENABLE) ? 1'b1 : ~(strb & ((bus_flavour_i == FLAV_RWLINE) | ~wr_r));
      dat_nxt = cdat_r;
      oen_nxt = ~(xfer & wr_r);
      if (bus_flavour_i == FLAV_ENABLE) begin
        mck_nxt = strb; // R1 R2
      end else if (bus_sync_i) begin
        mck_nxt = div_r; // R3 R5
      end else begin
        mck_nxt = ~xfer; // R3 R4
      end
    end else begin
      fs_nxt = (v_st_r == PH_SYNC); // R10
      ls_nxt = (h_st_r == PH_SYNC); // R11
      pc_nxt = pck_s2_r;
      acp_nxt = ac_r; // R8
      rsn_nxt = 1'b1;
      dat_nxt = pix_r; // R9
      oen_nxt = 1'b0;
      mck_nxt = 1'b0;
    end
  end
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      memory_clock_pin_o <= 1'b0;
      frame_sync_out_o <= 1'b0;
      line_sync_out_o <= 1'b0;
      pixel_clock_out_o <= 1'b0;
      ac_bias_out_o <= 1'b0;
      read_strobe_n_o <= 1'b1;
      pixel_data_bus_o <= PIX_RESET;
      pixel_data_bus_oe_n_o <= 1'b1;
    end else begin
      memory_clock_pin_o <= mck_nxt;
      frame_sync_out_o <= fs_nxt;
      line_sync_out_o <= ls_nxt;
      pixel_clock_out_o <= pc_nxt;
      ac_bias_out_o <= acp_nxt;
      read_strobe_n_o <= rsn_nxt;
      pixel_data_bus_o <= dat_nxt;
      pixel_data_bus_oe_n_o <= oen_nxt;
    end
  end

  // ==========================================================
  // Checks
  enable_pulse_a: assert property (@(posedge mclk_i) disable iff (reset_i) // R2
    (!$past(reset_i) && $past(display_bus_mode_i) && $past(bus_flavour_i) == FLAV_ENABLE)
      |-> memory_clock_pin_o == $past(bs_r == BS_STROBE)) else $error("enable strobe mismatch");
  async_cs_a: assert property (@(posedge mclk_i) disable iff (reset_i) // R4
    (display_bus_mode_i && bus_flavour_i != FLAV_ENABLE && !bus_sync_i && xfer)
      |=> !memory_clock_pin_o) else $error("second chip select not asserted");
  sync_clock_a: assert property (@(posedge mclk_i) disable iff (reset_i) // R5
    (display_bus_mode_i && bus_flavour_i != FLAV_ENABLE && bus_sync_i)[*2]
      |=> memory_clock_pin_o != $past(memory_clock_pin_o)) else $error("bus clock not running");
  frame_sync_a: assert property (@(posedge mclk_i) disable iff (reset_i) // R10
    (!$past(reset_i) && !$past(display_bus_mode_i))
      |-> frame_sync_out_o == $past(v_st_r == PH_SYNC)) else $error("frame sync wrong");
  line_sync_a: assert property (@(posedge mclk_i) disable iff (reset_i) // R11
    (!$past(reset_i) && !$past(display_bus_mode_i))
      |-> line_sync_out_o == $past(h_st_r == PH_SYNC)) else $error("line sync wrong");
  phase_order_a: assert property (@(posedge mclk_i) disable iff (reset_i) // R15
    (!$past(reset_i) && !display_bus_mode_i && h_st_r != $past(h_st_r) && !$past(display_bus_mode_i))
      |-> h_st_r == next_ph($past(h_st_r))) else $error("line phase out of order");
  engine_excl_a: assert property (@(posedge mclk_i) disable iff (reset_i) // R12
    display_bus_mode_i |=> (h_st_r == PH_SYNC && hcnt_r == CNT_ZERO && !pop)) else $error("raster ran in bus mode");
  pixel_window_a: assert property (@(posedge mclk_i) disable iff (reset_i) // R9
    pop |-> (h_st_r == PH_ACT && v_st_r == PH_ACT && pck_rise && !display_bus_mode_i))
      else $error("pixel taken outside active");
endmodule

// file: inc/lpt_pkg.sv
// Purpose: Shared constants and types for the panel timing engine
// Assumes: 50 MHz mclk_i, synchronous active-high reset
// Notes: Sync fields and horizontal porches use the stored-value-plus-one convention; vertical porches use the stored value
package lpt_pkg;
  // ==========================================================
  // Widths
  localparam int PIX_W = 16;
  localparam int CNT_W = 12;
  localparam int BCNT_W = 6;
  localparam int PPL_SHIFT = 4;
  localparam int FIFO_DEPTH = 2;
  // ==========================================================
  // Display-bus flavours
  localparam logic [1:0] FLAV_ENABLE = 2'h0;
  localparam logic [1:0] FLAV_RWLINE = 2'h1;
  localparam logic [1:0] FLAV_RWSTROBE = 2'h2;
  // ==========================================================
  // Reset values
  localparam logic [PIX_W-1:0] PIX_RESET = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;
  localparam logic [BCNT_W-1:0] BCNT_ZERO = 6'h00;
  // ==========================================================
  // States
  typedef enum logic [1:0] {
    PH_SYNC = 2'b00, PH_BACK = 2'b01, PH_ACT = 2'b11, PH_FRONT = 2'b10
  } lpt_phase_e;
  typedef enum logic [2:0] {
    BS_IDLE = 3'b000, BS_SETUP = 3'b001, BS_STROBE = 3'b011, BS_HOLD = 3'b010, BS_GAP = 3'b110
  } lpt_bus_e;
endpackage

// file: sim/lpt_panel_model.sv
// Purpose: Panel side: pixel clock source and bus read responder
// Assumes: Read data is driven only while the E pulse or the read strobe pin is active
// Notes: A released bus shows the inverted last value, never a stale copy
module lpt_panel_model
  import lpt_pkg::*;
(
  input wire logic mclk_i,
  input wire logic clk_run_i,
  input wire logic [1:0] flavour_i,
  input wire logic [PIX_W-1:0] reply_i,
  input wire logic memory_clock_pin_i,
  input wire logic read_strobe_n_i,
  output logic pix_clk_ref_o,
  output logic [PIX_W-1:0] bus_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [PIX_W-1:0] last_r = 16'h0000;
  logic rd_act;
  // ==========================================================
  // Link clock, runs only while clk_run_i is high; odd offset keeps its edges off mclk_i edges
  initial begin
    pix_clk_ref_o = 1'b0;
    forever begin
      #37;
      while (clk_run_i) begin
        #80 pix_clk_ref_o = ~pix_clk_ref_o;
      end
    end
  end
  // ==========================================================
  // Read responder
  assign rd_act = (flavour_i == FLAV_ENABLE) ? memory_clock_pin_i : ~read_strobe_n_i;
  always @(posedge mclk_i) begin
    if (rd_act) begin
      last_r <= reply_i;
    end
  end
  assign bus_o = rd_act ? reply_i : ~last_r;
endmodule

// file: sim/tb_top.sv
// Purpose: Self-checking bench for the panel timing engine
// Assumes: Small porches and a 16-pixel, 2-line frame keep runs short
// Notes: Pixel values are distinct so each change is one pixel
module tb_top
  import lpt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i = 1'b0, reset_i = 1'b1, bus_mode = 1'b0, bus_sync = 1'b0, clk_run = 1'b0;
  logic [1:0] flav = FLAV_ENABLE;
  logic [5:0] horizontal_sync_width = 6'h01, vertical_sync_width = 6'h01, st = 6'h06;
  logic [7:0] horizontal_back_porch = 8'h02, horizontal_front_porch = 8'h00, vertical_back_porch = 8'h01, vertical_front_porch = 8'h00, acb = 8'h01;
  logic [9:0] lcl = 10'h001;
  logic [4:0] su = 5'h02;
  logic [3:0] ho = 4'h2;
  logic pix_valid = 1'b0, cmd_valid = 1'b0, cmd_write = 1'b0, cmd_rs = 1'b0;
  logic [PIX_W-1:0] pix_data = 16'h0000, cmd_data = 16'h0000, reply = 16'h0000, bus_in, pdo, rd_data;
  logic [PIX_W-1:0] pdo_d = 16'h0000;
  logic pix_ready, cmd_ready, rd_valid, mcp, fso, lso, pco, aco, rsn, oen, pref;
  logic pco_d, lso_d, fso_d, aco_d;
  logic [PIX_W-1:0] exp_q[$];
  int error_cnt = 0, samples_checked = 0, cyc = 0, pl, ps, lf, lv, an;

  lpt_engine dut (.mclk_i(mclk_i), .reset_i(reset_i), .display_bus_mode_i(bus_mode), .bus_flavour_i(flav),
    .bus_sync_i(bus_sync), .vertical_front_porch_i(vertical_front_porch), .vertical_sync_width_i(vertical_sync_width),
    .vertical_back_porch_i(vertical_back_porch), .line_count_low_i(lcl), .line_count_ext_bit_i(1'b0),
    .horizontal_front_porch_i(horizontal_front_porch), .horizontal_sync_width_i(horizontal_sync_width), .horizontal_back_porch_i(horizontal_back_porch),
    .pixels_per_line_high_i(1'b0), .pixels_per_line_low_i(6'h00), .ac_bias_frequency_i(acb),
    .setup_cycles_i(su), .strobe_cycles_i(st), .hold_cycles_i(ho), .cs_delay_i(2'h1),
    .pix_clk_ref_i(pref), .pix_valid_i(pix_valid), .pix_data_i(pix_data), .pix_ready_o(pix_ready),
    .cmd_valid_i(cmd_valid), .cmd_write_i(cmd_write), .cmd_reg_sel_i(cmd_rs), .cmd_data_i(cmd_data),
    .cmd_ready_o(cmd_ready), .rd_valid_o(rd_valid), .rd_data_o(rd_data), .memory_clock_pin_o(mcp),
    .frame_sync_out_o(fso), .line_sync_out_o(lso), .pixel_clock_out_o(pco), .ac_bias_out_o(aco),
    .read_strobe_n_o(rsn), .pixel_data_bus_o(pdo), .pixel_data_bus_i(bus_in), .pixel_data_bus_oe_n_o(oen));

  lpt_panel_model panel (.mclk_i(mclk_i), .clk_run_i(clk_run), .flavour_i(flav), .reply_i(reply),
    .memory_clock_pin_i(mcp), .read_strobe_n_i(rsn), .pix_clk_ref_o(pref), .bus_o(bus_in));

  initial begin
    forever #10 mclk_i = ~mclk_i;
  end
  // ==========================================================
  // Compare, report
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic take(input string what, input logic [PIX_W-1:0] seen);
    logic [PIX_W-1:0] e;
    e = (exp_q.size() > 0) ? exp_q.pop_front() : ~seen;
    check(what, seen, e);
  endtask
  task automatic results();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      results();
    end
  end
  // ==========================================================
  // Output watcher
  always @(posedge mclk_i) begin
    if (!bus_mode && !reset_i && pdo !== pdo_d && pdo !== 16'h0000) take("pixel", pdo);
    if (rd_valid === 1'b1) take("read_data", rd_data);
    pdo_d = pdo;
    if (reset_i || bus_mode) begin
      pl = -1000;
      lf = -1000;
      an = -1000;
      ps = 0;
      lv = 0;
    end else begin
      if (fso && !fso_d) begin
        if (lf > 0) check("frame_len", 16'(lf), 16'(vertical_sync_width + vertical_back_porch + vertical_front_porch + lcl + 2));
        lf = 0;
        lv = 0;
      end
      if (!fso && fso_d) check("vsync_len", 16'(lv), 16'(vertical_sync_width + 1));
      if (aco !== aco_d) begin
        if (an >= 0) check("ac_bias", 16'(an), 16'(acb + 1));
        an = 0;
      end
      if (lso && !lso_d) begin
        if (pl > 0) check("line_len", 16'(pl), 16'(horizontal_sync_width + horizontal_back_porch + horizontal_front_porch + 19));
        pl = 0;
        ps = 0;
        lf++;
        an++;
        lv += fso;
      end
      if (!lso && lso_d) check("hsync_len", 16'(ps), 16'(horizontal_sync_width + 1));
      if (pco && !pco_d) begin
        pl++;
        ps += lso;
      end
    end
    pco_d = pco;
    lso_d = lso;
    fso_d = fso;
    aco_d = aco;
  end
  // ==========================================================
  // Drivers
  task automatic push_pix(input int n);
    int i, k;
    logic [PIX_W-1:0] v;
    for (i = 0; i < n; i++) begin
      v = {8'($urandom_range(255, 1)), 8'(i + 1)};
      pix_valid <= 1'b1;
      pix_data <= v;
      @(posedge mclk_i);
      for (k = 0; k < 2000 && pix_ready !== 1'b1; k++) @(posedge mclk_i);
      exp_q.push_back(v);
    end
    pix_valid <= 1'b0;
  endtask
  task automatic xfer(input logic wr, input logic [PIX_W-1:0] d);
    int k;
    int n[10];
    logic idle_mc, prev_mc;
    n = '{default: 0};
    cmd_valid <= 1'b1;
    cmd_write <= wr;
    cmd_rs <= d[0];
    cmd_data <= d;
    reply <= d;
    @(posedge mclk_i);
    for (k = 0; k < 100 && cmd_ready !== 1'b1; k++) @(posedge mclk_i);
    check("cmd_ready", {15'h0000, cmd_ready}, 16'h0001);
    cmd_valid <= 1'b0;
    if (!wr) exp_q.push_back(d);
    idle_mc = mcp;
    prev_mc = mcp;
    for (k = 0; k < 24; k++) begin
      @(posedge mclk_i);
      n[0] += (aco === 1'b0);
      n[1] += (fso === 1'b1);
      n[2] += (oen === 1'b0);
      n[3] += (mcp === 1'b1);
      n[4] += (mcp === 1'b0);
      n[5] += (mcp !== prev_mc);
      n[6] += (rsn === 1'b0);
      n[7] += (lso === 1'b0);
      n[8] += (aco === 1'b0 && pco !== d[0]);
      n[9] += (oen === 1'b0 && pdo !== d);
      prev_mc = mcp;
    end
    check("cs0_len", 16'(n[0]), 16'(su + st + ho));
    check("ale_len", 16'(n[1]), 16'(su));
    check("oe_len", 16'(n[2]), wr ? 16'(su + st + ho) : 16'h0000);
    check("rs_pin", 16'(n[8]), 16'h0000);
    check("wr_data", 16'(n[9]), 16'h0000);
    check("rd_strobe", 16'(n[6]), (flav == FLAV_RWLINE || (flav == FLAV_RWSTROBE && !wr)) ? 16'(st) : 16'h0000);
    check("ws_len", 16'(n[7]), !wr ? 16'h0000 : (flav == FLAV_RWSTROBE) ? 16'(st) : 16'(su + st + ho));
    if (flav == FLAV_ENABLE) check("e_pulse", 16'(n[3] + 100 * idle_mc), 16'(st));
    else if (bus_sync) check("bus_clk", 16'(n[5]), 16'h0018);
    else check("cs1_sel", 16'(n[4] > 0 && idle_mc), 16'h0001);
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(32'hA7EF5AD8));
    repeat (6) @(posedge mclk_i);
    reset_i <= 1'b0;
    clk_run <= 1'b1;
    @(posedge mclk_i);
    check("raster_cmd", {15'h0000, cmd_ready}, 16'h0000);
    push_pix(2);
    @(posedge mclk_i);
    check("buf_full", {15'h0000, pix_ready}, 16'h0000);
    push_pix(62);
    repeat (3500) @(posedge mclk_i);
    check("pix_left", 16'(exp_q.size()), 16'h0000);
    // Mid-run reset while switching engines
    bus_mode <= 1'b1;
    clk_run <= 1'b0;
    reset_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    reset_i <= 1'b0;
    for (int f = 0; f < 3; f++) begin
      for (int s = 0; s < 2; s++) begin
        flav <= f[1:0];
        bus_sync <= s[0];
        repeat (4) @(posedge mclk_i);
        xfer(1'b1, 16'($urandom));
        xfer(1'b0, 16'($urandom));
      end
    end
    repeat (20) @(posedge mclk_i);
    check("rd_left", 16'(exp_q.size()), 16'h0000);
    results();
  end
endmodule
